// ### shared/sbps_pkg.sv
// Constants, register map and bus carrier for the SCSI bus phase sequencer.
// Assumes a 200 MHz system clock; all timing counts are derived from it here.
package sbps_pkg;

  // Clock and bus timing, times in ns; least times round up to whole cycles
  localparam int unsigned CLK_NS          = 5;
  localparam int unsigned BUS_FREE_NS     = 800;
  localparam int unsigned BUS_FREE_CYC    = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ARB_DELAY_NS    = 2400;
  localparam int unsigned ARB_CYC         = (ARB_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETTLE_NS       = 400;
  localparam int unsigned SETTLE_CYC      = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned REQ_PULSE_NS    = 40;
  localparam int unsigned REQ_PULSE_CYC   = (REQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SEL_TIMEOUT_NS  = 250000000;
  localparam int unsigned SEL_TIMEOUT_CYC = (SEL_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TMR_W           = 26;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned SYNC_OFFSET     = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_CMD1   = 8'h08;
  localparam logic [7:0] ADDR_CMD2   = 8'h0C;
  localparam logic [7:0] ADDR_IDS    = 8'h10;
  localparam logic [7:0] ADDR_CNTLO  = 8'h14;
  localparam logic [7:0] ADDR_CNTMID = 8'h18;
  localparam logic [7:0] ADDR_CNTHI  = 8'h1C;
  localparam logic [7:0] ADDR_STAT   = 8'h20;
  localparam logic [7:0] ADDR_RXDATA = 8'h24;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMD2_RST = 8'h00;
  localparam logic [7:0] IDS_RST  = 8'h00;

  // Field positions
  localparam int unsigned MODE_INIT   = 0;
  localparam int unsigned MODE_ARB    = 1;
  localparam int unsigned CTRL_ATN    = 0;
  localparam int unsigned CTRL_SELRSP = 1;
  localparam int unsigned CTRL_RESRSP = 2;
  localparam int unsigned CTRL_SYNC   = 3;
  localparam int unsigned CTRL_PARCHK = 4;
  localparam int unsigned CMD1_DISC   = 5;
  localparam int unsigned CMD1_SEL    = 6;
  localparam int unsigned CMD2_DIN    = 1;
  localparam int unsigned CMD2_CMD    = 2;
  localparam int unsigned CMD2_STAT   = 3;
  localparam int unsigned CMD2_MOUT   = 6;
  localparam int unsigned CMD2_MIN    = 7;
  localparam int unsigned IDS_OWN_LO  = 0;
  localparam int unsigned IDS_DST_LO  = 4;
  localparam int unsigned ST_DONE     = 0;
  localparam int unsigned ST_SELOK    = 1;
  localparam int unsigned ST_SELTMO   = 2;
  localparam int unsigned ST_PICKED   = 3;
  localparam int unsigned ST_ARBLOST  = 4;
  localparam int unsigned ST_BUSY     = 5;
  localparam int unsigned ST_CONN     = 6;
  localparam int unsigned ST_XFER     = 7;

  // Phase codes as {message, command/data, input/output}
  localparam logic [2:0] PH_DOUT = 3'h0;
  localparam logic [2:0] PH_DIN  = 3'h1;
  localparam logic [2:0] PH_CMD  = 3'h2;
  localparam logic [2:0] PH_STAT = 3'h3;
  localparam logic [2:0] PH_MOUT = 3'h6;
  localparam logic [2:0] PH_MIN  = 3'h7;

  // Bus lines, one bit each meaning asserted
  typedef struct packed {
    logic       rst;
    logic       bsy;
    logic       sel;
    logic       atn;
    logic       ack;
    logic       req;
    logic       msg;
    logic       cd;
    logic       io;
    logic       par;
    logic [7:0] data;
  } sbps_bus_t;

  localparam int unsigned BUS_W = $bits(sbps_bus_t);

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_WFREE = 6'h02,
    S_ARB   = 6'h04,
    S_SEL   = 6'h08,
    S_CONN  = 6'h10,
    S_XFER  = 6'h20
  } sbps_state_t;

endpackage

// ### src/sbps_sequencer.sv
// SCSI bus phase sequencer: arbitration, (re)selection and target phases.
// Assumes an APB master on sys_clk and pin buffers that turn the oe/out
// pairs into open-collector, active-low bus wires.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module sbps_sequencer #(
  parameter int unsigned SEL_TIMEOUT_CYC = sbps_pkg::SEL_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // APB slave
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // SCSI bus lines
  input  wire sbps_pkg::sbps_bus_t busIn,
  output sbps_pkg::sbps_bus_t      busOut,
  output sbps_pkg::sbps_bus_t      busOe,
  // Byte stream on the user side
  input  wire logic [7:0]          txByte,
  output logic                     txTake,
  output logic      [7:0]          rxByte,
  output logic                     rxValid
);

  if (SEL_TIMEOUT_CYC >= (2 ** sbps_pkg::TMR_W) ||
      SEL_TIMEOUT_CYC <= 2 * sbps_pkg::SETTLE_CYC) begin : g_bad_timeout
    $error("SEL_TIMEOUT_CYC out of range for the timer");
  end

  localparam logic [sbps_pkg::TMR_W-1:0] T_FREE   = sbps_pkg::TMR_W'(sbps_pkg::BUS_FREE_CYC - 1);
  localparam logic [sbps_pkg::TMR_W-1:0] T_ARB    = sbps_pkg::TMR_W'(sbps_pkg::ARB_CYC - 1);
  localparam logic [sbps_pkg::TMR_W-1:0] T_SETTLE = sbps_pkg::TMR_W'(sbps_pkg::SETTLE_CYC);
  localparam logic [sbps_pkg::TMR_W-1:0] T_LOOK   = sbps_pkg::TMR_W'(2 * sbps_pkg::SETTLE_CYC);
  localparam logic [sbps_pkg::TMR_W-1:0] T_SELTMO = sbps_pkg::TMR_W'(SEL_TIMEOUT_CYC);
  localparam logic [sbps_pkg::TMR_W-1:0] T_PULSE  = sbps_pkg::TMR_W'(sbps_pkg::REQ_PULSE_CYC);
  localparam logic [sbps_pkg::CNT_W-1:0] C_OFFSET = sbps_pkg::CNT_W'(sbps_pkg::SYNC_OFFSET);

  // One-hot identifier bit from a 3-bit identifier
  function automatic logic [7:0] idBit(input logic [2:0] id);
    idBit = 8'h01 << id;
  endfunction

  // True when no more than two data bits are set
  function automatic logic fewIds(input logic [7:0] d);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, d[i]};
    end
    fewIds = (n <= 4'h2);
  endfunction

  // Phase code from command register 2, message bits taking priority
  function automatic logic [2:0] phaseOf(input logic [7:0] c);
    if (c[sbps_pkg::CMD2_MIN])       phaseOf = sbps_pkg::PH_MIN;
    else if (c[sbps_pkg::CMD2_MOUT]) phaseOf = sbps_pkg::PH_MOUT;
    else if (c[sbps_pkg::CMD2_STAT]) phaseOf = sbps_pkg::PH_STAT;
    else if (c[sbps_pkg::CMD2_CMD])  phaseOf = sbps_pkg::PH_CMD;
    else if (c[sbps_pkg::CMD2_DIN])  phaseOf = sbps_pkg::PH_DIN;
    else                             phaseOf = sbps_pkg::PH_DOUT;
  endfunction

  // Pin synchroniser: three flops, a change counts once stages two and three agree
  logic [sbps_pkg::BUS_W-1:0] syncA_r;
  logic [sbps_pkg::BUS_W-1:0] syncB_r;
  logic [sbps_pkg::BUS_W-1:0] syncC_r;
  logic [sbps_pkg::BUS_W-1:0] busF_r;
  logic                       ackPrev_r;
  sbps_pkg::sbps_bus_t        bf;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r   <= '0;
      syncB_r   <= '0;
      syncC_r   <= '0;
      busF_r    <= '0;
      ackPrev_r <= 1'b0;
    end else begin
      syncA_r   <= busIn;
      syncB_r   <= syncA_r;
      syncC_r   <= syncB_r;
      busF_r    <= (syncB_r & syncC_r) | (busF_r & (syncB_r ^ syncC_r));
      ackPrev_r <= bf.ack;
    end
  end
  assign bf = sbps_pkg::sbps_bus_t'(busF_r);

  // APB decode; every access takes one wait state so outputs stay registered
  logic [7:0] modeR_r, ctrlR_r, cmd2R_r, idsR_r;
  logic [sbps_pkg::CNT_W-1:0] cnt_r, cnt_nxt, reqLeft_r, reqLeft_nxt;
  logic [7:0] rxByte_r;
  logic doneF_r, selOkF_r, selTmoF_r, pickedF_r, arbLostF_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  sbps_pkg::sbps_state_t state_r, state_nxt;

  wire       apbAcc   = psel & penable;
  wire       apbFirst = apbAcc & ~pready_r;
  wire       wrEn     = apbAcc & pready_r & pwrite;
  wire [7:0] wb       = pwdata[7:0];
  wire hitMode   = (paddr == sbps_pkg::ADDR_MODE);
  wire hitCtrl   = (paddr == sbps_pkg::ADDR_CTRL);
  wire hitCmd1   = (paddr == sbps_pkg::ADDR_CMD1);
  wire hitCmd2   = (paddr == sbps_pkg::ADDR_CMD2);
  wire hitIds    = (paddr == sbps_pkg::ADDR_IDS);
  wire hitCntLo  = (paddr == sbps_pkg::ADDR_CNTLO);
  wire hitCntMid = (paddr == sbps_pkg::ADDR_CNTMID);
  wire hitCntHi  = (paddr == sbps_pkg::ADDR_CNTHI);
  wire hitStat   = (paddr == sbps_pkg::ADDR_STAT);
  wire hitRx     = (paddr == sbps_pkg::ADDR_RXDATA);
  wire mapped    = hitMode | hitCtrl | hitCmd1 | hitCmd2 | hitIds | hitCntLo |
                   hitCntMid | hitCntHi | hitStat | hitRx;
  wire selCmd    = wrEn & hitCmd1 & wb[sbps_pkg::CMD1_SEL];
  wire discCmd   = wrEn & hitCmd1 & wb[sbps_pkg::CMD1_DISC];
  wire startCmd  = wrEn & hitCntLo;
  wire stClr     = wrEn & hitStat;

  wire [7:0] statByte = {state_r == sbps_pkg::S_XFER, state_r == sbps_pkg::S_CONN,
                         state_r != sbps_pkg::S_IDLE, arbLostF_r, pickedF_r,
                         selTmoF_r, selOkF_r, doneF_r};
  wire [7:0] rdByte = hitMode   ? modeR_r :
                      hitCtrl   ? ctrlR_r :
                      hitCmd2   ? cmd2R_r :
                      hitIds    ? idsR_r :
                      hitCntLo  ? cnt_r[7:0] :
                      hitCntMid ? cnt_r[15:8] :
                      hitCntHi  ? cnt_r[23:16] :
                      hitStat   ? statByte :
                      hitRx     ? rxByte_r : 8'h00;

  // Bus answer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= apbFirst;
      pslverr_r <= apbFirst & ~mapped;
      prdata_r  <= (apbFirst & ~pwrite) ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeR_r <= sbps_pkg::MODE_RST;
      ctrlR_r <= sbps_pkg::CTRL_RST;
      cmd2R_r <= sbps_pkg::CMD2_RST;
      idsR_r  <= sbps_pkg::IDS_RST;
    end else begin
      if (wrEn & hitMode) modeR_r <= wb;
      if (wrEn & hitCtrl) ctrlR_r <= wb;
      if (wrEn & hitCmd2) cmd2R_r <= wb;
      if (wrEn & hitIds)  idsR_r  <= wb;
    end
  end

  // Mode and identifier decode
  wire       initMode = modeR_r[sbps_pkg::MODE_INIT];
  wire       arbEn    = modeR_r[sbps_pkg::MODE_ARB];
  wire [7:0] ownId    = idBit(idsR_r[sbps_pkg::IDS_OWN_LO +: 3]);
  wire [7:0] dstId    = idBit(idsR_r[sbps_pkg::IDS_DST_LO +: 3]);
  wire [7:0] higher   = ~(ownId | (ownId - 8'h01));
  wire       busFree  = ~bf.bsy & ~bf.sel;
  wire       arbLost  = |(bf.data & higher) | bf.sel;
  wire       parityOk = ^{bf.data, bf.par};
  wire       rspEn    = bf.io ? ctrlR_r[sbps_pkg::CTRL_RESRSP]
                              : ctrlR_r[sbps_pkg::CTRL_SELRSP];
  wire       picked   = bf.sel & ~bf.bsy & |(bf.data & ownId) & fewIds(bf.data) &
                        (~ctrlR_r[sbps_pkg::CTRL_PARCHK] | parityOk) & rspEn;

  // Transfer state
  logic [sbps_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
  logic [2:0] phase_r;
  logic       phaseOn_r, reqOut_r, reqOut_nxt;
  logic [7:0] txHold_r;
  logic       txTake_r, rxValid_r;

  wire inXfer   = (state_r == sbps_pkg::S_XFER);
  wire syncMode = ctrlR_r[sbps_pkg::CTRL_SYNC] & (phase_r[2:1] == 2'b00);
  wire ackRise  = bf.ack & ~ackPrev_r;
  wire [sbps_pkg::CNT_W-1:0] inFlight = cnt_r - reqLeft_r;
  wire issue    = inXfer & ~reqOut_r & (reqLeft_r != '0) &
                  (syncMode ? (inFlight < C_OFFSET) : ~bf.ack);
  wire byteDone = inXfer & (syncMode ? ackRise : (reqOut_r & bf.ack));
  wire xferEnd  = inXfer & (cnt_r == '0) & ~reqOut_r & ~bf.ack;
  wire [sbps_pkg::CNT_W-1:0] loadCnt = {cnt_r[23:8], wb};

  // Main sequencer
  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r + 1'b1;
    unique case (state_r)
      sbps_pkg::S_IDLE: begin
        tmr_nxt = '0;
        if (selCmd) state_nxt = sbps_pkg::S_WFREE;
        else if (picked) state_nxt = sbps_pkg::S_CONN;
      end
      sbps_pkg::S_WFREE: begin
        if (!busFree) tmr_nxt = '0;
        if (picked) begin
          state_nxt = sbps_pkg::S_CONN;
        end else if (busFree && tmr_r >= T_FREE) begin
          state_nxt = arbEn ? sbps_pkg::S_ARB : sbps_pkg::S_SEL;
          tmr_nxt   = '0;
        end
      end
      sbps_pkg::S_ARB: begin
        if (tmr_r >= T_ARB) begin
          state_nxt = arbLost ? sbps_pkg::S_WFREE : sbps_pkg::S_SEL;
          tmr_nxt   = '0;
        end
      end
      sbps_pkg::S_SEL: begin
        if (tmr_r >= T_LOOK && bf.bsy) state_nxt = sbps_pkg::S_CONN;
        else if (tmr_r >= T_SELTMO) state_nxt = sbps_pkg::S_IDLE;
      end
      sbps_pkg::S_CONN: begin
        tmr_nxt = '0;
        if (discCmd) state_nxt = sbps_pkg::S_IDLE;
        else if (startCmd && !initMode) state_nxt = sbps_pkg::S_XFER;
        else if (initMode && !bf.bsy && !busOe.bsy) state_nxt = sbps_pkg::S_IDLE;
      end
      sbps_pkg::S_XFER: begin
        if (issue || !reqOut_r) tmr_nxt = '0;
        if (discCmd) state_nxt = sbps_pkg::S_IDLE;
        else if (xferEnd && !startCmd) state_nxt = sbps_pkg::S_CONN;
      end
    endcase
  end

  // Request line and counters
  always_comb begin
    reqOut_nxt  = reqOut_r;
    cnt_nxt     = cnt_r;
    reqLeft_nxt = reqLeft_r;
    if (!inXfer) reqOut_nxt = 1'b0;
    else if (issue) reqOut_nxt = 1'b1;
    else if (syncMode ? (tmr_r >= T_PULSE - 1'b1) : bf.ack) reqOut_nxt = 1'b0;
    if (issue) reqLeft_nxt = reqLeft_r - 1'b1;
    if (byteDone && cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
    if (wrEn & hitCntMid) cnt_nxt = {cnt_r[23:16], wb, cnt_r[7:0]};
    if (wrEn & hitCntHi)  cnt_nxt = {wb, cnt_r[15:0]};
    if (startCmd) begin
      cnt_nxt     = loadCnt;
      reqLeft_nxt = loadCnt;
      reqOut_nxt  = 1'b0;
    end
  end

  // State, counters, phase latch and byte path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= sbps_pkg::S_IDLE;
      tmr_r     <= '0;
      cnt_r     <= '0;
      reqLeft_r <= '0;
      reqOut_r  <= 1'b0;
      phase_r   <= sbps_pkg::PH_DOUT;
      phaseOn_r <= 1'b0;
      txHold_r  <= 8'h00;
      txTake_r  <= 1'b0;
      rxByte_r  <= 8'h00;
      rxValid_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      tmr_r     <= tmr_nxt;
      cnt_r     <= cnt_nxt;
      reqLeft_r <= reqLeft_nxt;
      reqOut_r  <= reqOut_nxt;
      if (startCmd && (state_r == sbps_pkg::S_CONN || inXfer) && !initMode) begin
        phase_r   <= phaseOf(cmd2R_r);
        phaseOn_r <= 1'b1;
      end else if (state_nxt == sbps_pkg::S_IDLE) begin
        phaseOn_r <= 1'b0;
      end
      if (issue) txHold_r <= txByte;
      txTake_r  <= issue & phase_r[0];
      if (byteDone && !phase_r[0]) rxByte_r <= bf.data;
      rxValid_r <= byteDone & ~phase_r[0];
    end
  end

  // Sticky status flags; a set in the clearing cycle wins
  wire selOkSet  = (state_r == sbps_pkg::S_SEL) & (state_nxt == sbps_pkg::S_CONN);
  wire selTmoSet = (state_r == sbps_pkg::S_SEL) & (state_nxt == sbps_pkg::S_IDLE);
  wire pickedSet = (state_r != sbps_pkg::S_SEL) & (state_r != sbps_pkg::S_CONN) &
                   (state_nxt == sbps_pkg::S_CONN);
  wire lostSet   = (state_r == sbps_pkg::S_ARB) & (state_nxt == sbps_pkg::S_WFREE);
  wire doneSet   = xferEnd & (state_nxt == sbps_pkg::S_CONN);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneF_r    <= 1'b0;
      selOkF_r   <= 1'b0;
      selTmoF_r  <= 1'b0;
      pickedF_r  <= 1'b0;
      arbLostF_r <= 1'b0;
    end else begin
      doneF_r    <= doneSet   | (doneF_r    & ~(stClr & wb[sbps_pkg::ST_DONE]));
      selOkF_r   <= selOkSet  | (selOkF_r   & ~(stClr & wb[sbps_pkg::ST_SELOK]));
      selTmoF_r  <= selTmoSet | (selTmoF_r  & ~(stClr & wb[sbps_pkg::ST_SELTMO]));
      pickedF_r  <= pickedSet | (pickedF_r  & ~(stClr & wb[sbps_pkg::ST_PICKED]));
      arbLostF_r <= lostSet   | (arbLostF_r & ~(stClr & wb[sbps_pkg::ST_ARBLOST]));
    end
  end

  // Line drive; open-collector lines are driven only while asserted, except data and parity while a transfer sends bytes
  sbps_pkg::sbps_bus_t drv, outNxt, oeNxt, busOut_r, busOe_r;
  logic [7:0] dataNxt;
  logic       dataAll;

  always_comb begin
    drv     = '0;
    dataNxt = 8'h00;
    dataAll = 1'b0;
    unique case (state_r)
      sbps_pkg::S_IDLE, sbps_pkg::S_WFREE: begin
      end
      sbps_pkg::S_ARB: begin
        drv.bsy = 1'b1;
        dataNxt = ownId;
      end
      sbps_pkg::S_SEL: begin
        drv.sel = 1'b1;
        drv.bsy = arbEn & (tmr_r < T_SETTLE);
        drv.io  = initMode;
        drv.atn = initMode & ctrlR_r[sbps_pkg::CTRL_ATN];
        dataNxt = ownId | dstId;
      end
      sbps_pkg::S_CONN, sbps_pkg::S_XFER: begin
        drv.bsy = ~initMode | bf.sel;
        drv.msg = phaseOn_r & phase_r[2];
        drv.cd  = phaseOn_r & phase_r[1];
        drv.io  = phaseOn_r & phase_r[0];
        drv.req = reqOut_r;
        if (inXfer && phase_r[0]) begin
          dataNxt = txHold_r;
          dataAll = 1'b1;
        end
      end
    endcase
    outNxt      = drv;
    oeNxt       = drv;
    outNxt.data = dataNxt;
    oeNxt.data  = dataAll ? 8'hFF : dataNxt;
    outNxt.par  = (state_r != sbps_pkg::S_ARB) & ~^dataNxt;
    oeNxt.par   = (state_r != sbps_pkg::S_ARB) & (dataAll | outNxt.par);
  end

  // Output registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busOut_r <= '0;
      busOe_r  <= '0;
    end else begin
      busOut_r <= outNxt;
      busOe_r  <= oeNxt;
    end
  end

  assign busOut  = busOut_r;
  assign busOe   = busOe_r;
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign txTake  = txTake_r;
  assign rxByte  = rxByte_r;
  assign rxValid = rxValid_r;

endmodule

// ### tb/sbps_far_dev.sv
// Far-end bus device: answers (re)selection and handshakes bytes.
// Assumes asserted-high bus values; released lines read deasserted.
`timescale 1ns/1ps
module sbps_far_dev (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // Behaviour knobs
  input  wire logic                answer,
  input  wire logic                slow,
  input  wire logic [2:0]          farId,
  input  wire logic [7:0]          selIds,
  // Bus as the device asserts it, and what we assert
  input  wire sbps_pkg::sbps_bus_t devBus,
  output sbps_pkg::sbps_bus_t      farBus
);
  logic [3:0] reqDly_r;
  logic [7:0] byteNo_r;
  wire        ackNxt = devBus.req && (slow ? reqDly_r[3] : reqDly_r[0]);
  // Ack trails request by two or five cycles; data lines go back to the
  // pull-up level once released, so stale bytes never linger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reqDly_r <= 4'h0;
      byteNo_r <= 8'h00;
      farBus   <= '0;
    end else begin
      reqDly_r    <= {reqDly_r[2:0], devBus.req};
      farBus.bsy  <= answer && devBus.sel && devBus.data[farId];
      farBus.ack  <= ackNxt;
      // Non-zero selIds makes us select the device with those id bits
      farBus.sel  <= |selIds;
      farBus.data <= selIds | ((ackNxt && !devBus.io) ? byteNo_r : 8'h00);
      if (farBus.ack && !devBus.req) byteNo_r <= byteNo_r + 8'h01;
    end
  end
endmodule

// ### tb/sbps_seq_asserts.sv
// Port checker for the bus phase sequencer.
// Assumes it is bound to sbps_sequencer and sees only its ports.
`timescale 1ns/1ps
module sbps_seq_asserts (
  // Clock, reset and APB
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic [7:0]          paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  // Bus lines
  input wire sbps_pkg::sbps_bus_t busIn,
  input wire sbps_pkg::sbps_bus_t busOut,
  input wire sbps_pkg::sbps_bus_t busOe
);
  logic [1:0] mode_r;
  logic       atnEn_r;
  wire        apbWr = psel && penable && pready && pwrite;
  wire  [7:0] drv   = busOut.data & busOe.data;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Mirror of mode and attention enable as software left them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r  <= 2'h0;
      atnEn_r <= 1'h0;
    end else if (apbWr) begin
      if (paddr == sbps_pkg::ADDR_MODE) mode_r <= pwdata[1:0];
      if (paddr == sbps_pkg::ADDR_CTRL) atnEn_r <= pwdata[0];
    end
  end
  // Busy raised while nobody selects: arbitration begins
  sequence arbStart;
    $rose(busOe.bsy) && !busOe.sel && !$past(busOe.sel) && !busIn.sel;
  endsequence
  sequence selByUs;
    busOe.sel && busOut.sel;
  endsequence
  a_arb_own_bit: assert property (arbStart |-> $countones(drv) == 1)
    else $error("arbitration without a single id bit");
  a_arb_enabled: assert property (arbStart |-> mode_r[1])
    else $error("arbitration while disabled");
  a_arb_no_parity: assert property (arbStart |-> (!busOe.par)[*8])
    else $error("parity driven in arbitration");
  a_sel_two_ids: assert property (selByUs |-> $countones(drv) == 2)
    else $error("select without both id bits");
  a_sel_mode_io: assert property (selByUs |-> busOe.io == mode_r[0])
    else $error("select phase kind does not match mode");
  a_sel_atn: assert property ((selByUs and mode_r[0]) |-> busOe.atn == atnEn_r)
    else $error("attention wrong in selection");
  a_req_async: assert property ($rose(busOut.req) && (busOut.msg || busOut.cd) |-> !busIn.ack)
    else $error("request raised before ack released");
  a_req_ack_end: assert property ($fell(busOut.req) && busOut.cd |-> $past(busIn.ack))
    else $error("request dropped without ack");
  a_phase_held: assert property (busOut.req && $past(busOut.req) |-> $stable(busOut[11:9]))
    else $error("phase lines moved in a handshake");
endmodule
bind sbps_sequencer sbps_seq_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .busIn(busIn), .busOut(busOut), .busOe(busOe));

// ### tb/test_scsi_bus_phase_sequencer.sv
// Self-checking bench for the bus phase sequencer.
// Assumes the far-end model and the bound port checker.
`timescale 1ns/1ps
module test_scsi_bus_phase_sequencer;
  logic                sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic                answer, slow, err, sawArb, reqPrev, txTake, rxValid;
  logic [7:0]          paddr, rxByte, txSeen, selIds;
  logic [2:0]          farId;
  logic [31:0]         pwdata, prdata, rd;
  sbps_pkg::sbps_bus_t busIn, busOut, busOe, farBus;
  int                  err_total, checks_done, reqRises, nTake, nGot;
  // Wired-OR bus as seen by the sequencer; the far end sees only what the sequencer drives
  assign busIn = sbps_pkg::sbps_bus_t'((busOut & busOe) | farBus);
  always #2.5 sys_clk = ~sys_clk;
  sbps_sequencer #(.SEL_TIMEOUT_CYC(2000)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busIn(busIn), .busOut(busOut),
    .busOe(busOe), .txByte(8'h5A), .txTake(txTake), .rxByte(rxByte), .rxValid(rxValid));
  sbps_far_dev i_far (.sys_clk(sys_clk), .rst_n(rst_n), .answer(answer), .slow(slow),
    .farId(farId), .selIds(selIds), .devBus(sbps_pkg::sbps_bus_t'(busOut & busOe)),
    .farBus(farBus));
  // Count request rises driven onto the bus, byte pulses, and keep the sent byte
  always @(posedge sys_clk) begin
    if (busOut.req && busOe.req && !reqPrev) reqRises++;
    if (busOut.req && busOe.req && !reqPrev && busOut.io) txSeen = busOut.data;
    nTake += txTake;
    nGot += rxValid;
    reqPrev <= busOut.req && busOe.req;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic waitStat(input int b, input logic v);
    repeat (3000) begin
      apb(sbps_pkg::ADDR_STAT, 1'b0, 32'h0);
      if (rd[b] === v) break;
    end
  endtask
  task automatic waitSel();
    sawArb = 1'b0;
    repeat (2000) begin
      @(posedge sys_clk);
      if (busOe.bsy && !busOe.sel) sawArb = 1'b1;
      if (busOe.sel) break;
    end
  endtask
  task automatic testReset();
    apb(sbps_pkg::ADDR_MODE, 1'b0, 32'h0);
    check(rd, 32'h0);
    apb(sbps_pkg::ADDR_CTRL, 1'b0, 32'h0);
    check(rd, 32'h0);
    apb(8'h3C, 1'b1, 32'hFF);
    check({31'h0, err}, 32'h1);
  endtask
  task automatic testTarget();
    logic [7:0] cmds [6] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h00};
    logic [2:0] phs [6] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
    int         nb [6] = '{2, 2, 2, 6, 2, 2};
    logic [7:0] lastRx [6] = '{8'h00, 8'h03, 8'h00, 8'h0B, 8'h00, 8'h0F};
    farId <= 3'h6;
    answer <= 1'b1;
    apb(sbps_pkg::ADDR_IDS, 1'b1, 32'h62);
    // Far side selects us first, so the reselection follows a disconnect
    apb(sbps_pkg::ADDR_CTRL, 1'b1, 32'h2);
    selIds <= 8'h44;
    waitStat(sbps_pkg::ST_PICKED, 1'b1);
    check(rd[sbps_pkg::ST_PICKED], 1'b1);
    selIds <= 8'h00;
    apb(sbps_pkg::ADDR_CMD1, 1'b1, 32'h20);
    apb(sbps_pkg::ADDR_CMD1, 1'b1, 32'h40);
    waitSel();
    check(busOut.data & busOe.data, 32'h44);
    check(sawArb, 1'b0);
    waitStat(sbps_pkg::ST_SELOK, 1'b1);
    check(rd[sbps_pkg::ST_SELOK], 1'b1);
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      apb(sbps_pkg::ADDR_CTRL, 1'b1, (i == 4) ? 32'h8 : 32'h0);
      apb(sbps_pkg::ADDR_CMD2, 1'b1, {24'h0, cmds[i]});
      apb(sbps_pkg::ADDR_CNTHI, 1'b1, 32'h0);
      apb(sbps_pkg::ADDR_CNTMID, 1'b1, 32'h0);
      {reqRises, nTake, nGot} = '0;
      apb(sbps_pkg::ADDR_CNTLO, 1'b1, (i == 3) ? 32'h1 : 32'h2);
      if (i == 3) begin
        // Group code of the first command byte sets the block length
        waitStat(sbps_pkg::ST_DONE, 1'b1);
        apb(sbps_pkg::ADDR_STAT, 1'b1, 32'h1);
        apb(sbps_pkg::ADDR_RXDATA, 1'b0, 32'h0);
        check(rd, 32'h6);
        apb(sbps_pkg::ADDR_CNTLO, 1'b1, (rd[7:5] == 3'h0) ? 32'h5 : 32'h9);
      end
      waitStat(sbps_pkg::ST_DONE, 1'b1);
      check(rd[sbps_pkg::ST_DONE], 1'b1);
      check(reqRises, nb[i]);
      check(phs[i][0] ? nTake : nGot, nb[i]);
      if (!phs[i][0]) check(rxByte, lastRx[i]);
      check(busOut[11:9] & busOe[11:9], phs[i]);
      apb(sbps_pkg::ADDR_STAT, 1'b1, 32'h1);
    end
    check(txSeen, 8'h5A);
    apb(sbps_pkg::ADDR_CMD1, 1'b1, 32'h20);
    waitStat(sbps_pkg::ST_CONN, 1'b0);
    check(busOe[11:9], 3'h0);
  endtask
  task automatic testInit(input logic atn);
    farId <= 3'h5;
    answer <= atn;
    apb(sbps_pkg::ADDR_IDS, 1'b1, 32'h53);
    apb(sbps_pkg::ADDR_MODE, 1'b1, 32'h3);
    apb(sbps_pkg::ADDR_CTRL, 1'b1, {31'h0, atn});
    apb(sbps_pkg::ADDR_STAT, 1'b1, 32'h1F);
    apb(sbps_pkg::ADDR_CMD1, 1'b1, 32'h40);
    waitSel();
    check(sawArb, 1'b1);
    check({busOut.atn, busOut.io, busOut.data} & {busOe.atn, busOe.io, busOe.data},
          {atn, 9'h128});
    waitStat(atn ? sbps_pkg::ST_SELOK : sbps_pkg::ST_SELTMO, 1'b1);
    check(rd[2:1], atn ? 2'h1 : 2'h2);
    apb(sbps_pkg::ADDR_CMD1, 1'b1, 32'h20);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized well above the longest expected run
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    {sys_clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {answer, slow, farId, reqPrev, selIds} = '0;
    err_total = 0;
    checks_done = 0;
    reqRises = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    testReset();
    testTarget();
    testInit(1'b1);
    testInit(1'b0);
    wrap_up();
  end
endmodule
